// ===== sus_link_model.sv
// far-end device model on the shift clock and serial data lines
`timescale 1ns/1ps
module sus_link_model (
  // lines seen from the port
  input wire logic mclk_i,
  input wire logic dat_i,
  // character setup
  input wire logic [3:0] nbits_i,
  input wire logic [8:0] base_i,
  // lines driven by the model
  output logic clk_o,
  output logic dat_o
);
  logic [3:0] idx = 4'h0;
  logic [8:0] nchar = 9'h000;
  logic [8:0] cap = 9'h000;
  logic [8:0] mcap = 9'h000;
  logic [8:0] ch;

  assign ch = base_i + nchar * 9'h055;
  initial clk_o = 1'b0;
  initial dat_o = 1'b0;

  // data changes on the leading edge
  always @(posedge mclk_i) begin
    dat_o <= ch[idx];
    if (idx == nbits_i - 4'h1) begin
      idx <= 4'h0;
      nchar <= nchar + 9'h001;
    end else begin
      idx <= idx + 4'h1;
    end
  end

  // data line inverted after the last bit
  always @(negedge mclk_i) begin
    mcap <= {dat_i, mcap[8:1]};
    if (idx == 4'h0) begin
      dat_o <= ~dat_o;
    end
  end

  task automatic restart();
    idx = 4'h0;
    nchar = 9'h000;
  endtask

  // one nine-bit frame, clock low outside it; sdat feeds a slave receiver
  task automatic frame(input logic [8:0] sdat);
    #13;
    for (int i = 0; i < 9; i++) begin
      clk_o = 1'b1;
      dat_o = sdat[i];
      #160;
      clk_o = 1'b0;
      cap = {dat_i, cap[8:1]};
      #160;
    end
  endtask
endmodule

// ===== sus_pkg.sv
// package for the synchronous serial port: register map, fields, reset values
package sus_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] SUS_TX_CTL_OFS = 3'h0;
  localparam logic [2:0] SUS_RX_CTL_OFS = 3'h1;
  localparam logic [2:0] SUS_BAUD_CTL_OFS = 3'h2;
  localparam logic [2:0] SUS_DIV_LO_OFS = 3'h3;
  localparam logic [2:0] SUS_DIV_HI_OFS = 3'h4;
  localparam logic [2:0] SUS_RX_DATA_OFS = 3'h5;
  localparam logic [2:0] SUS_TX_DATA_OFS = 3'h6;
  localparam logic [2:0] SUS_INT_CTL_OFS = 3'h7;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SUS_WIDE_DIV_BIT = 3;
  localparam int SUS_INT_TX_FLAG_BIT = 0;
  localparam int SUS_INT_RX_FLAG_BIT = 1;

  // ----------------------------------------------------------------
  // reset values, character lengths and buffer depth
  // ----------------------------------------------------------------
  localparam logic [7:0] SUS_CTL_RST = 8'h00;
  localparam logic [15:0] SUS_DIV_RST = 16'h0000;
  localparam logic [3:0] SUS_BITS_8 = 4'h8;
  localparam logic [3:0] SUS_BITS_9 = 4'h9;
  localparam logic [1:0] SUS_FIFO_DEPTH = 2'h2;

  // ----------------------------------------------------------------
  // register layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic clock_source_master;
    logic nine_bit_transmit_select;
    logic transmit_enable;
    logic clocked_mode;
    logic spare;
    logic high_speed_baud_select;
    logic shift_empty;
    logic transmit_ninth_bit;
  } sus_tx_ctl_type;

  typedef struct packed {
    logic port_enable;
    logic nine_bit_receive_select;
    logic single_receive_enable;
    logic continuous_receive_enable;
    logic [1:0] spare;
    logic overrun_error_flag;
    logic receive_ninth_bit;
  } sus_rx_ctl_type;

  typedef struct packed {
    logic global_interrupt_enable;
    logic peripheral_interrupt_enable;
    logic receive_interrupt_enable;
    logic transmit_interrupt_enable;
    logic [1:0] spare;
    logic receive_ready_flag;
    logic transmit_buffer_empty_flag;
  } sus_int_ctl_type;

endpackage

// ===== sus_port.sv
// synchronous serial port: master receive, slave and master transmit
// ------------------------------------------------------------------
// Functional notes
// - clocked mode, enable, clock master: master
// - nine-bit select gives nine bits, else eight
// - single or continuous enable starts master receive
// - each character sets receive ready, maybe interrupt
// - clearing continuous or port enable clears overrun; while single is set, code clears it after clearing continuous only on a data read
// - slave needs clocked, not master, port enabled
// - slave takes shift clock from clock line
// - slave transmits when both receive enables clear
// - port works only while enabled
// - slave transmit equals master, external clock
// - first written word moves at once to shifter
// - second word waits, buffer empty flag clear
// - after shifting, second word moves, flag sets
// - wake on flag with enables, vector if global
// - transmitter works only while transmit enabled
// - ninth transmit bit sent as ninth bit
// - writing transmit data starts a transmission
// - slave clock pin undriven, data changes leading
// - two-deep receive buffer, third sets overrun
// - single receive clears itself after one character
// ------------------------------------------------------------------
`timescale 1ns/1ps
module sus_port (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // register port
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // shift clock line
  input wire logic shift_clk_i,
  output logic shift_clk_o,
  output logic shift_clk_oe_n_o,
  // serial data line
  input wire logic serial_data_i,
  output logic serial_data_o,
  output logic serial_data_oe_n_o,
  // core wake and interrupt
  output logic wake_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  sus_pkg::sus_tx_ctl_type tx_ctl_q;
  sus_pkg::sus_rx_ctl_type rx_ctl_q;
  sus_pkg::sus_int_ctl_type int_ctl_q;
  logic wide_div_q;
  logic [15:0] div_q;
  logic [7:0] rdata_q;

  logic wr_tx_ctl, wr_rx_ctl, wr_baud, wr_lo, wr_hi, wr_tx_data, wr_int, rd_rx_data;
  assign wr_tx_ctl = reg_wr_i && (reg_addr_i == sus_pkg::SUS_TX_CTL_OFS);
  assign wr_rx_ctl = reg_wr_i && (reg_addr_i == sus_pkg::SUS_RX_CTL_OFS);
  assign wr_baud = reg_wr_i && (reg_addr_i == sus_pkg::SUS_BAUD_CTL_OFS);
  assign wr_lo = reg_wr_i && (reg_addr_i == sus_pkg::SUS_DIV_LO_OFS);
  assign wr_hi = reg_wr_i && (reg_addr_i == sus_pkg::SUS_DIV_HI_OFS);
  assign wr_tx_data = reg_wr_i && (reg_addr_i == sus_pkg::SUS_TX_DATA_OFS);
  assign wr_int = reg_wr_i && (reg_addr_i == sus_pkg::SUS_INT_CTL_OFS);
  assign rd_rx_data = reg_rd_i && (reg_addr_i == sus_pkg::SUS_RX_DATA_OFS);

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  logic port_on, master, slave, rx_req, tx_mode, port_clr;
  assign port_on = rx_ctl_q.port_enable && tx_ctl_q.clocked_mode;
  assign master = port_on && tx_ctl_q.clock_source_master;
  assign slave = port_on && !tx_ctl_q.clock_source_master;
  assign rx_req = rx_ctl_q.single_receive_enable || rx_ctl_q.continuous_receive_enable;
  assign tx_mode = !rx_req;
  // clearing the port enable resets the shifters, buffers, baud generator and overrun flag, not the other control bits
  assign port_clr = srst_i || !rx_ctl_q.port_enable;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic ck_s1_q, ck_s2_q, ck_s3_q, dt_s1_q, dt_s2_q;
  always_ff @(posedge sys_clk_i) begin
    ck_s1_q <= shift_clk_i;
    ck_s2_q <= ck_s1_q;
    ck_s3_q <= ck_s2_q;
    dt_s1_q <= serial_data_i;
    dt_s2_q <= dt_s1_q;
  end

  // ----------------------------------------------------------------
  // state declarations
  // ----------------------------------------------------------------
  logic [8:0] fifo_q [0:1];
  logic fifo_head_q;
  logic [1:0] fifo_cnt_q;
  logic [8:0] rx_shreg_q;
  logic [3:0] rx_cnt_q;
  logic [7:0] tx_buf_q;
  logic tx_full_q;
  logic [8:0] tx_shreg_q;
  logic [3:0] tx_cnt_q;
  logic tx_busy_q;
  logic [15:0] baud_cnt_q;
  logic clk_q;
  logic dout_q;

  logic rx_active, rx_done, tx_load, tx_fin, run, tick, lead, trail;
  logic [3:0] rx_bits, tx_bits;
  logic [15:0] div_eff;
  assign rx_bits = rx_ctl_q.nine_bit_receive_select ? sus_pkg::SUS_BITS_9
                                                    : sus_pkg::SUS_BITS_8;
  assign tx_bits = tx_ctl_q.nine_bit_transmit_select ? sus_pkg::SUS_BITS_9
                                                     : sus_pkg::SUS_BITS_8;
  // a slave ignores single receive; a master honours both enables
  assign rx_active = !rx_ctl_q.overrun_error_flag &&
    ((master && rx_req) || (slave && rx_ctl_q.continuous_receive_enable));
  assign div_eff = wide_div_q ? div_q : {8'h00, div_q[7:0]};

  // ----------------------------------------------------------------
  // baud generator and master shift clock
  // ----------------------------------------------------------------
  assign run = master && (rx_active || (tx_mode && tx_busy_q));
  assign tick = run && (baud_cnt_q == 16'h0000);

  always_ff @(posedge sys_clk_i) begin
    if (port_clr || !run) begin
      baud_cnt_q <= div_eff;
    end else if (tick) begin
      baud_cnt_q <= div_eff;
    end else begin
      baud_cnt_q <= baud_cnt_q - 16'h0001;
    end
  end

  // idle low; a stop mid character drops the clock at once
  always_ff @(posedge sys_clk_i) begin
    if (port_clr || !run) begin
      clk_q <= 1'b0;
    end else if (tick) begin
      clk_q <= !clk_q;
    end
  end

  // leading edge rises, trailing edge falls
  assign lead = master ? (tick && !clk_q) : (slave && ck_s2_q && !ck_s3_q);
  assign trail = master ? (tick && clk_q) : (slave && !ck_s2_q && ck_s3_q);

  // ----------------------------------------------------------------
  // receive shifter
  // ----------------------------------------------------------------
  assign rx_done = rx_active && trail && (rx_cnt_q == rx_bits - 4'h1);

  always_ff @(posedge sys_clk_i) begin
    if (port_clr || !rx_active) begin
      rx_cnt_q <= 4'h0; // partial character discarded
      rx_shreg_q <= 9'h000;
    end else if (trail) begin
      rx_shreg_q[rx_cnt_q] <= dt_s2_q;
      rx_cnt_q <= rx_done ? 4'h0 : rx_cnt_q + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // receive buffer, two characters deep
  // ----------------------------------------------------------------
  logic [8:0] rx_char;
  logic push, pop;
  always_comb begin
    rx_char = rx_shreg_q;
    rx_char[rx_cnt_q] = dt_s2_q;
    if (!rx_ctl_q.nine_bit_receive_select) begin
      rx_char[8] = 1'b0;
    end
  end
  assign push = rx_done && ((fifo_cnt_q != sus_pkg::SUS_FIFO_DEPTH) || pop);
  assign pop = rd_rx_data && (fifo_cnt_q != 2'h0);

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      fifo_q[fifo_head_q ^ fifo_cnt_q[0]] <= rx_char;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (port_clr) begin
      fifo_head_q <= 1'b0;
      fifo_cnt_q <= 2'h0;
    end else begin
      if (pop) begin
        fifo_head_q <= !fifo_head_q;
      end
      fifo_cnt_q <= fifo_cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // ----------------------------------------------------------------
  // transmit buffer and shifter
  // ----------------------------------------------------------------
  logic tx_on;
  assign tx_on = port_on && tx_mode && tx_ctl_q.transmit_enable;
  assign tx_load = tx_on && tx_full_q && !tx_busy_q;
  assign tx_fin = tx_busy_q && trail && (tx_cnt_q == tx_bits);

  always_ff @(posedge sys_clk_i) begin
    if (port_clr || !tx_ctl_q.transmit_enable) begin
      tx_full_q <= 1'b0;
      tx_buf_q <= 8'h00;
    end else if (wr_tx_data) begin
      tx_full_q <= 1'b1;
      tx_buf_q <= reg_wdata_i;
    end else if (tx_load) begin
      tx_full_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (port_clr || !tx_on) begin
      tx_busy_q <= 1'b0;
      tx_cnt_q <= 4'h0;
      tx_shreg_q <= 9'h000;
    end else if (tx_load) begin
      tx_busy_q <= 1'b1;
      tx_cnt_q <= 4'h0;
      tx_shreg_q <= {tx_ctl_q.transmit_ninth_bit, tx_buf_q};
    end else if (tx_fin) begin
      tx_busy_q <= 1'b0;
    end else if (lead && tx_busy_q && (tx_cnt_q != tx_bits)) begin
      tx_shreg_q <= {1'b0, tx_shreg_q[8:1]};
      tx_cnt_q <= tx_cnt_q + 4'h1;
    end
  end

  // data changes on the leading edge, valid at the trailing edge
  always_ff @(posedge sys_clk_i) begin
    if (port_clr || !tx_on) begin
      dout_q <= 1'b0;
    end else if (lead && tx_busy_q && (tx_cnt_q != tx_bits)) begin
      dout_q <= tx_shreg_q[0];
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      shift_clk_o <= 1'b0;
      shift_clk_oe_n_o <= 1'b1;
      serial_data_o <= 1'b0;
      serial_data_oe_n_o <= 1'b1;
    end else begin
      shift_clk_o <= clk_q;
      shift_clk_oe_n_o <= !master;
      serial_data_o <= dout_q;
      serial_data_oe_n_o <= !tx_on;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      tx_ctl_q <= sus_pkg::SUS_CTL_RST;
    end else if (wr_tx_ctl) begin
      tx_ctl_q <= reg_wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rx_ctl_q <= sus_pkg::SUS_CTL_RST;
    end else begin
      if (wr_rx_ctl) begin
        rx_ctl_q.port_enable <= reg_wdata_i[7];
        rx_ctl_q.nine_bit_receive_select <= reg_wdata_i[6];
        rx_ctl_q.continuous_receive_enable <= reg_wdata_i[4];
      end
      // single receive stops itself after one character
      if (rx_done && master) begin
        rx_ctl_q.single_receive_enable <= 1'b0;
      end else if (wr_rx_ctl) begin
        rx_ctl_q.single_receive_enable <= reg_wdata_i[5];
      end
      // set wins over every clear except srst_i
      if (rx_done && (fifo_cnt_q == sus_pkg::SUS_FIFO_DEPTH) && !pop) begin
        rx_ctl_q.overrun_error_flag <= 1'b1;
      end else if (port_clr || !rx_ctl_q.continuous_receive_enable &&
                   (!rx_ctl_q.single_receive_enable || rd_rx_data)) begin
        rx_ctl_q.overrun_error_flag <= 1'b0;
      end
      rx_ctl_q.spare <= 2'b00;
      rx_ctl_q.receive_ninth_bit <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      wide_div_q <= 1'b0;
      div_q <= sus_pkg::SUS_DIV_RST;
    end else begin
      if (wr_baud) begin
        wide_div_q <= reg_wdata_i[sus_pkg::SUS_WIDE_DIV_BIT];
      end
      if (wr_lo) begin
        div_q[7:0] <= reg_wdata_i;
      end
      if (wr_hi) begin
        div_q[15:8] <= reg_wdata_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      int_ctl_q <= sus_pkg::SUS_CTL_RST;
    end else if (wr_int) begin
      int_ctl_q <= {reg_wdata_i[7:4], 4'h0};
    end
  end

  // ----------------------------------------------------------------
  // wake and interrupt
  // ----------------------------------------------------------------
  logic tx_empty, rx_ready, wake_d;
  assign tx_empty = !tx_full_q;
  assign rx_ready = fifo_cnt_q != 2'h0;
  assign wake_d = int_ctl_q.peripheral_interrupt_enable &&
    ((int_ctl_q.transmit_interrupt_enable && tx_empty) ||
     (int_ctl_q.receive_interrupt_enable && rx_ready));

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      wake_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      wake_o <= wake_d;
      irq_o <= wake_d && int_ctl_q.global_interrupt_enable;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [8:0] head_char;
  logic [7:0] rd_mux;
  assign head_char = rx_ready ? fifo_q[fifo_head_q] : 9'h000;

  always_comb begin
    rd_mux = 8'h00;
    case (reg_addr_i)
      sus_pkg::SUS_TX_CTL_OFS: begin
        rd_mux = {tx_ctl_q[7:2], !tx_busy_q, tx_ctl_q[0]};
      end
      sus_pkg::SUS_RX_CTL_OFS: begin
        rd_mux = {rx_ctl_q[7:1], head_char[8]};
      end
      sus_pkg::SUS_BAUD_CTL_OFS: begin
        rd_mux[sus_pkg::SUS_WIDE_DIV_BIT] = wide_div_q;
      end
      sus_pkg::SUS_DIV_LO_OFS: begin
        rd_mux = div_q[7:0];
      end
      sus_pkg::SUS_DIV_HI_OFS: begin
        rd_mux = div_q[15:8];
      end
      sus_pkg::SUS_RX_DATA_OFS: begin
        rd_mux = head_char[7:0];
      end
      sus_pkg::SUS_INT_CTL_OFS: begin
        rd_mux = int_ctl_q;
        rd_mux[sus_pkg::SUS_INT_RX_FLAG_BIT] = rx_ready;
        rd_mux[sus_pkg::SUS_INT_TX_FLAG_BIT] = tx_empty;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rdata_q <= 8'h00;
    end else if (reg_rd_i) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata_o = rdata_q;

endmodule

// ===== sus_port_chk.sv
// concurrent checks on the synchronous serial port pins and register port
`timescale 1ns/1ps
module sus_port_chk (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // register port
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // pins and wake
  input wire logic shift_clk_o,
  input wire logic shift_clk_oe_n_o,
  input wire logic serial_data_oe_n_o,
  input wire logic wake_o,
  input wire logic irq_o
);
  // ----------------------------------------------------------------
  // shadow of written controls
  // ----------------------------------------------------------------
  logic [7:0] tx_q;
  logic [7:0] rx_q;
  logic [7:0] int_q;
  logic [7:0] lo_q;
  logic [7:0] hi_q;
  logic wide_q;
  logic clk_q;
  logic [15:0] run_q;
  logic master_w;
  logic [15:0] half_w;

  assign master_w = tx_q[7] && tx_q[4] && rx_q[7];
  assign half_w = wide_q ? {hi_q, lo_q} : {8'h00, lo_q};

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      int_q <= 8'h00;
      lo_q <= 8'h00;
      hi_q <= 8'h00;
      wide_q <= 1'b0;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        sus_pkg::SUS_TX_CTL_OFS: tx_q <= reg_wdata_i;
        sus_pkg::SUS_RX_CTL_OFS: rx_q <= reg_wdata_i;
        sus_pkg::SUS_INT_CTL_OFS: int_q <= reg_wdata_i;
        sus_pkg::SUS_DIV_LO_OFS: lo_q <= reg_wdata_i;
        sus_pkg::SUS_DIV_HI_OFS: hi_q <= reg_wdata_i;
        sus_pkg::SUS_BAUD_CTL_OFS: wide_q <= reg_wdata_i[sus_pkg::SUS_WIDE_DIV_BIT];
        default: ;
      endcase
    end
  end

  // cycles the shift clock has held its level
  always_ff @(posedge sys_clk_i) begin
    clk_q <= shift_clk_o;
    if (srst_i || shift_clk_o != clk_q) begin
      run_q <= 16'h0000;
    end else if (run_q != 16'hffff) begin
      run_q <= run_q + 16'h0001;
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);

  a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data not zero outside a read reply");
  a_master_clk_oe: assert property (!shift_clk_oe_n_o |-> master_w || $past(master_w))
    else $error("clock pin driven outside master mode");
  a_port_off_quiet: assert property ((!rx_q[7] && !$past(rx_q[7])) |->
    shift_clk_oe_n_o && serial_data_oe_n_o)
    else $error("pin driven while port disabled");
  a_tx_needs_enable: assert property (!serial_data_oe_n_o |-> tx_q[5] || $past(tx_q[5]))
    else $error("data pin driven with transmitter off");
  a_clk_idle_low: assert property (shift_clk_oe_n_o |-> !shift_clk_o)
    else $error("shift clock high while not driven");
  a_clk_high_time: assert property ($fell(shift_clk_o) |-> run_q == half_w)
    else $error("shift clock high phase length wrong");
  a_clk_low_time: assert property ($rose(shift_clk_o) |-> run_q >= half_w)
    else $error("shift clock low phase too short");
  a_wake_enables: assert property (wake_o |-> int_q[6] || $past(int_q[6]))
    else $error("wake without peripheral enable");
  a_irq_global: assert property (irq_o |-> wake_o && (int_q[7] || $past(int_q[7])))
    else $error("interrupt without wake or global enable");

  c_clk_run: cover property ($fell(shift_clk_o));
  c_wake_only: cover property (wake_o && !irq_o);
  c_irq: cover property (irq_o);
  c_tx_drive: cover property (!serial_data_oe_n_o);
endmodule

bind sus_port sus_port_chk sus_port_chk_i (
  .sys_clk_i(sys_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .shift_clk_o(shift_clk_o),
  .shift_clk_oe_n_o(shift_clk_oe_n_o), .serial_data_oe_n_o(serial_data_oe_n_o),
  .wake_o(wake_o), .irq_o(irq_o)
);

// ===== tb_top.sv
// self-checking testbench for the synchronous serial port
`timescale 1ns/1ps
`define CHK(g, e) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end
module tb_top;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [2:0] reg_addr_i = 3'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic shift_clk_o, shift_clk_oe_n_o, serial_data_o, serial_data_oe_n_o;
  logic wake_o, irq_o, p_clk, p_dat;
  logic [3:0] p_nbits = 4'h8;
  logic [8:0] p_base = 9'h1a5;
  logic [7:0] d;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  wire logic clk_w = shift_clk_oe_n_o ? p_clk : shift_clk_o;
  wire logic dat_w = serial_data_oe_n_o ? p_dat : serial_data_o;

  always #20 sys_clk_i = ~sys_clk_i;

  sus_port sus_port_i (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .shift_clk_i(clk_w), .shift_clk_o(shift_clk_o),
    .shift_clk_oe_n_o(shift_clk_oe_n_o), .serial_data_i(dat_w),
    .serial_data_o(serial_data_o), .serial_data_oe_n_o(serial_data_oe_n_o),
    .wake_o(wake_o), .irq_o(irq_o)
  );
  sus_link_model sus_link_model_i (
    .mclk_i(shift_clk_o), .dat_i(dat_w), .nbits_i(p_nbits), .base_i(p_base),
    .clk_o(p_clk), .dat_o(p_dat)
  );

  task automatic complete_run();
    if (miscompares == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    v = reg_rdata_o;
    @(posedge sys_clk_i);
    #1;
  endtask

  task automatic poll(input logic [2:0] a, input int b, input logic v);
    rd(a, d);
    for (int i = 0; i < 12000 && d[b] !== v; i++) begin
      rd(a, d);
    end
  endtask

  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 80000) begin
      miscompares++;
      complete_run();
    end
  end

  initial begin
    repeat (4) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    @(posedge sys_clk_i);
    rd(sus_pkg::SUS_DIV_LO_OFS, d);
    `CHK(d, sus_pkg::SUS_DIV_RST[7:0])
    wr(sus_pkg::SUS_DIV_LO_OFS, 8'h03);
    wr(sus_pkg::SUS_DIV_HI_OFS, 8'h01);
    rd(sus_pkg::SUS_DIV_HI_OFS, d);
    `CHK(d, 8'h01)
    rd(sus_pkg::SUS_TX_DATA_OFS, d);
    `CHK(d, 8'h00)
    // master single receive, eight bits
    wr(sus_pkg::SUS_BAUD_CTL_OFS, 8'h00);
    wr(sus_pkg::SUS_TX_CTL_OFS, 8'h90);
    wr(sus_pkg::SUS_RX_CTL_OFS, 8'h80);
    wr(sus_pkg::SUS_INT_CTL_OFS, 8'h60);
    `CHK(shift_clk_oe_n_o, 1'b0)
    wr(sus_pkg::SUS_RX_CTL_OFS, 8'ha0);
    poll(sus_pkg::SUS_INT_CTL_OFS, 1, 1'b1);
    `CHK(d[1], 1'b1)
    `CHK({wake_o, irq_o}, 2'b10)
    wr(sus_pkg::SUS_INT_CTL_OFS, 8'he0);
    `CHK(irq_o, 1'b1)
    rd(sus_pkg::SUS_RX_CTL_OFS, d);
    `CHK(d[5], 1'b0)
    rd(sus_pkg::SUS_RX_DATA_OFS, d);
    `CHK(d, 8'ha5)
    rd(sus_pkg::SUS_INT_CTL_OFS, d);
    `CHK(d[1], 1'b0)
    // continuous nine-bit receive into overrun
    sus_link_model_i.restart();
    p_nbits = 4'h9;
    p_base = 9'h0f0;
    wr(sus_pkg::SUS_BAUD_CTL_OFS, 8'h08);
    wr(sus_pkg::SUS_RX_CTL_OFS, 8'hd0);
    poll(sus_pkg::SUS_RX_CTL_OFS, 1, 1'b1);
    `CHK(d[1:0], 2'b10)
    rd(sus_pkg::SUS_RX_DATA_OFS, d);
    `CHK(d, 8'hf0)
    rd(sus_pkg::SUS_RX_CTL_OFS, d);
    `CHK(d[0], 1'b1)
    rd(sus_pkg::SUS_RX_DATA_OFS, d);
    `CHK(d, 8'h45)
    rd(sus_pkg::SUS_INT_CTL_OFS, d);
    `CHK(d[1], 1'b0)
    wr(sus_pkg::SUS_RX_CTL_OFS, 8'hc0);
    rd(sus_pkg::SUS_RX_CTL_OFS, d);
    `CHK(d[1], 1'b0)
    // master transmit, eight bits on its own clock
    wr(sus_pkg::SUS_BAUD_CTL_OFS, 8'h00);
    wr(sus_pkg::SUS_TX_CTL_OFS, 8'hb0);
    wr(sus_pkg::SUS_TX_DATA_OFS, 8'h5a);
    poll(sus_pkg::SUS_TX_CTL_OFS, 1, 1'b1);
    `CHK(sus_link_model_i.mcap[8:1], 8'h5a)
    // slave transmit, nine bits, two words queued
    wr(sus_pkg::SUS_RX_CTL_OFS, 8'h00);
    wr(sus_pkg::SUS_RX_CTL_OFS, 8'h80);
    wr(sus_pkg::SUS_TX_CTL_OFS, 8'h50);
    wr(sus_pkg::SUS_TX_DATA_OFS, 8'h11);
    rd(sus_pkg::SUS_INT_CTL_OFS, d);
    `CHK({d[0], serial_data_oe_n_o}, 2'b11)
    wr(sus_pkg::SUS_TX_CTL_OFS, 8'h71);
    `CHK({shift_clk_oe_n_o, serial_data_oe_n_o}, 2'b10)
    wr(sus_pkg::SUS_INT_CTL_OFS, 8'h50);
    wr(sus_pkg::SUS_TX_DATA_OFS, 8'ha5);
    repeat (3) @(posedge sys_clk_i);
    rd(sus_pkg::SUS_INT_CTL_OFS, d);
    `CHK({d[0], wake_o}, 2'b11)
    wr(sus_pkg::SUS_TX_DATA_OFS, 8'h3c);
    repeat (3) @(posedge sys_clk_i);
    rd(sus_pkg::SUS_INT_CTL_OFS, d);
    `CHK({d[0], wake_o}, 2'b00)
    sus_link_model_i.frame(9'h000);
    `CHK(sus_link_model_i.cap, 9'h1a5)
    repeat (4) @(posedge sys_clk_i);
    rd(sus_pkg::SUS_INT_CTL_OFS, d);
    `CHK({d[0], wake_o, irq_o}, 3'b110)
    sus_link_model_i.frame(9'h000);
    `CHK(sus_link_model_i.cap, 9'h13c)
    // slave receive, nine bits, continuous enable only
    wr(sus_pkg::SUS_TX_CTL_OFS, 8'h50);
    wr(sus_pkg::SUS_RX_CTL_OFS, 8'hd0);
    sus_link_model_i.frame(9'h1c3);
    rd(sus_pkg::SUS_RX_CTL_OFS, d);
    `CHK(d[1:0], 2'b01)
    rd(sus_pkg::SUS_RX_DATA_OFS, d);
    `CHK(d, 8'hc3)
    complete_run();
  end
endmodule
